// file: core/gpio_cell_pkg.sv
package gpio_cell_pkg;

  // register port geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register byte addresses, one aligned word each
  localparam logic [7:0] CFG_ADDR  = 8'h00;
  localparam logic [7:0] STAT_ADDR = 8'h04;

  // pin modes; gray steps along idle-input-bidir-output
  typedef enum logic [2:0] {
    MODE_IDLE   = 3'h0,
    MODE_INPUT  = 3'h1,
    MODE_BIDIR  = 3'h3,
    MODE_OUTPUT = 3'h2,
    MODE_CLKOUT = 3'h6
  } pin_mode_t;

  // configuration word field positions
  localparam int CFG_MODE_LSB      = 0;
  localparam int CFG_MODE_W        = 3;
  localparam int CFG_IN_REG        = 3;
  localparam int CFG_IN_FALL       = 4;
  localparam int CFG_OUT_REG       = 5;
  localparam int CFG_OUT_FALL      = 6;
  localparam int CFG_OE_REG        = 7;
  localparam int CFG_OE_FALL       = 8;
  localparam int CFG_OUT_INVERT    = 9;
  localparam int CFG_DOUBLE_EDGE_IO_IN       = 10;
  localparam int CFG_DOUBLE_EDGE_IO_OUT      = 11;
  localparam int CFG_RESYNC        = 12;
  localparam int CFG_ALT_SEL       = 13;
  localparam int CFG_UNUSED_PULLDN = 14;

  // writable bits and value after reset
  localparam logic [31:0] CFG_WMASK = 32'h0000_7FFF;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;

  // status word field positions
  localparam int STAT_PAD      = 0;
  localparam int STAT_IN0      = 1;
  localparam int STAT_IN1      = 2;
  localparam int STAT_OE       = 3;
  localparam int STAT_PULLUP   = 4;
  localparam int STAT_PULLDN   = 5;
  localparam int STAT_CONFIGNG = 6;

  // value of every data flop after reset
  localparam logic BIT_RESET = 1'b0;

endpackage

// file: core/edge_if.sv
`timescale 1ns/100ps
// sampled pin clock as level plus one-cycle edge events
interface edge_if;
  logic level;
  logic rise;
  logic fall;

  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface

// file: core/clock_edge_sense.sv
`timescale 1ns/100ps
// brings a pin-side clock into clk and marks its edges
module clock_edge_sense (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pin_clk,
  edge_if.src       sense
);
  import gpio_cell_pkg::*;

  logic meta_reg;
  logic meta_next;
  logic sync_reg;
  logic sync_next;
  logic last_reg;
  logic last_next;

  // two-flop synchroniser, then one stage of history
  always_comb begin
    meta_next = pin_clk;
    sync_next = meta_reg;
    last_next = sync_reg;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= BIT_RESET;
      sync_reg <= BIT_RESET;
      last_reg <= BIT_RESET;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      last_reg <= last_next;
    end
  end

  // edges from synced stages only, never from meta
  assign sense.level = sync_reg;
  assign sense.rise  = sync_reg & ~last_reg;
  assign sense.fall  = ~sync_reg & last_reg;

endmodule // clock_edge_sense

// file: core/gpio_io_logic_cell.sv
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/100ps
//
// Contract
// [R1] input mode: receive only; optional register on chosen input clock edge
// [R2] alternate route forwards pad to alternate destination, no register
// [R3] double-edge receive: rising and falling samples as two core bits
// [R4] output mode: transmit only; optional register on chosen output edge
// [R5] optional inversion of output value in output and bidirectional modes
// [R6] double-edge transmit: two bits, one per edge, muxed onto pad
// [R7] bidirectional: receive, transmit and drive-enable all active
// [R8] bidirectional: per-register edge and per-path registering choices
// [R9] drive-enable switches pad buffer drive, optionally registered
// [R10] clock-output mode drives pad from the clock tree directly
// [R11] during configuration ordinary pins undriven with weak pull-up
// [R12] during configuration differential pins undriven, no pulls
// [R13] unused pins in user mode: pull-up by default, pull-down selectable; differential pins here always pull up, pull-down select ignored
// [R14] resync mode delays falling sample to next rising edge
// [R15] bit zero is rising-edge data, bit one falling-edge data
// [R16] differential pins offer no double-edge receive or transmit
// [R17] drive off means high impedance; receive still sees pad level
module gpio_io_logic_cell #(
  parameter bit DIFF_PIN_SINGLE_ENDED = 1'b0
) (
  input  wire logic                            clk,
  input  wire logic                            rst_n,
  input  wire logic [gpio_cell_pkg::ADDR_W-1:0] addr,
  input  wire logic [gpio_cell_pkg::DATA_W-1:0] wr_data,
  input  wire logic                            wr_en,
  input  wire logic                            rd_en,
  output logic      [gpio_cell_pkg::DATA_W-1:0] rd_data,
  input  wire logic                            config_done,
  input  wire logic                            in_clk,
  input  wire logic                            out_clk,
  input  wire logic                            tree_clk,
  input  wire logic                            rise_edge_output_bit,
  input  wire logic                            fall_edge_output_bit,
  input  wire logic                            core_oe,
  output logic                                 rise_edge_input_bit,
  output logic                                 fall_edge_input_bit,
  output logic                                 alt_out,
  input  wire logic                            pad_in,
  output logic                                 pad_out,
  output logic                                 pad_oe,
  output logic                                 pull_up_en,
  output logic                                 pull_down_en
);
  import gpio_cell_pkg::*;

  edge_if in_edge ();
  edge_if out_edge ();

  logic [DATA_W-1:0] cfg_reg;
  logic [DATA_W-1:0] cfg_next;
  logic [DATA_W-1:0] rd_data_reg;
  logic [DATA_W-1:0] rd_data_next;
  logic [DATA_W-1:0] status;
  logic              pad_meta_reg;
  logic              pad_meta_next;
  logic              pad_sync_reg;
  logic              pad_sync_next;
  logic              in0_reg;
  logic              in0_next;
  logic              in1_reg;
  logic              in1_next;
  logic              fall_hold_reg;
  logic              fall_hold_next;
  logic              tx0_reg;
  logic              tx0_next;
  logic              tx1_reg;
  logic              tx1_next;
  logic              oe_cap_reg;
  logic              oe_cap_next;
  logic              pad_out_reg;
  logic              pad_out_next;
  logic              pad_oe_reg;
  logic              pad_oe_next;
  logic              pull_up_reg;
  logic              pull_up_next;
  logic              pull_dn_reg;
  logic              pull_dn_next;
  logic              clk_out_reg;
  logic              clk_out_next;
  logic              alt_sel_reg;
  logic              alt_sel_next;
  pin_mode_t         mode;
  logic              configuring;
  logic              rx_en;
  logic              tx_en;
  logic              double_edge_io_in_ok;
  logic              double_edge_io_out_ok;
  logic              in_cap;
  logic              out_cap;
  logic              oe_cap;
  logic              tx_data;
  logic              oe_val;

  // pin clocks are asynchronous to clk, sensed as edge events
  clock_edge_sense u_in_sense (
    .clk     (clk),
    .rst_n   (rst_n),
    .pin_clk (in_clk),
    .sense   (in_edge)
  );

  clock_edge_sense u_out_sense (
    .clk     (clk),
    .rst_n   (rst_n),
    .pin_clk (out_clk),
    .sense   (out_edge)
  );

  // mode decode; unassigned codes behave as an unused pin
  always_comb begin
    mode        = pin_mode_t'(cfg_reg[CFG_MODE_LSB +: CFG_MODE_W]);
    configuring = ~config_done;
    rx_en       = 1'b0;
    tx_en       = 1'b0;
    unique case (mode)
      MODE_INPUT:  rx_en = 1'b1;               // see [R1]
      MODE_OUTPUT: tx_en = 1'b1;               // see [R4]
      MODE_BIDIR: begin
        rx_en = 1'b1;                          // see [R7]
        tx_en = 1'b1;
      end
      MODE_IDLE:   rx_en = 1'b0;
      MODE_CLKOUT: tx_en = 1'b0;
      default:     rx_en = 1'b0;
    endcase
    if (configuring) begin
      rx_en = 1'b0;
      tx_en = 1'b0;
    end
    // differential pins never get double-edge logic
    double_edge_io_in_ok  = cfg_reg[CFG_DOUBLE_EDGE_IO_IN] & (mode == MODE_INPUT)
                  & ~DIFF_PIN_SINGLE_ENDED;    // see [R16]
    double_edge_io_out_ok = cfg_reg[CFG_DOUBLE_EDGE_IO_OUT] & (mode == MODE_OUTPUT)
                  & ~DIFF_PIN_SINGLE_ENDED;    // see [R16]
    // each register picks its own edge
    in_cap  = cfg_reg[CFG_IN_FALL]  ? in_edge.fall  : in_edge.rise;
    out_cap = cfg_reg[CFG_OUT_FALL] ? out_edge.fall : out_edge.rise;
    oe_cap  = cfg_reg[CFG_OE_FALL]  ? out_edge.fall : out_edge.rise;
  end

  // pad level synchroniser; pad is read even while not driven
  always_comb begin
    pad_meta_next = pad_in;                    // see [R17]
    pad_sync_next = pad_meta_reg;
  end

  // receive path
  always_comb begin
    in0_next       = in0_reg;
    in1_next       = in1_reg;
    fall_hold_next = fall_hold_reg;
    if (!rx_en) begin
      in0_next       = 1'b0;
      in1_next       = 1'b0;
      fall_hold_next = 1'b0;
    end else if (double_edge_io_in_ok) begin
      // rise and fall events never coincide from one level
      if (in_edge.rise) begin
        in0_next = pad_sync_reg;               // see [R3] [R15]
        if (cfg_reg[CFG_RESYNC]) begin
          in1_next = fall_hold_reg;            // see [R14]
        end
      end
      if (in_edge.fall) begin
        if (cfg_reg[CFG_RESYNC]) begin
          fall_hold_next = pad_sync_reg;       // see [R14]
        end else begin
          in1_next = pad_sync_reg;             // see [R3] [R15]
        end
      end
    end else if (cfg_reg[CFG_IN_REG]) begin
      if (in_cap) begin
        in0_next = pad_sync_reg;               // see [R1] [R8]
      end
      in1_next = 1'b0;
    end else begin
      in0_next = pad_sync_reg;                 // see [R8]
      in1_next = 1'b0;
    end
  end

  // transmit and drive-enable capture
  always_comb begin
    tx0_next    = tx0_reg;
    tx1_next    = tx1_reg;
    oe_cap_next = oe_cap_reg;
    if (double_edge_io_out_ok) begin
      if (out_edge.rise) begin
        tx0_next = rise_edge_output_bit;       // see [R6] [R15]
      end
      if (out_edge.fall) begin
        tx1_next = fall_edge_output_bit;       // see [R6] [R15]
      end
    end else if (cfg_reg[CFG_OUT_REG]) begin
      if (out_cap) begin
        tx0_next = rise_edge_output_bit;       // see [R4] [R8]
      end
    end else begin
      tx0_next = rise_edge_output_bit;
    end
    if (cfg_reg[CFG_OE_REG] && oe_cap) begin
      oe_cap_next = core_oe;                   // see [R9]
    end
  end

  // pad drive, enable and pulls
  always_comb begin
    // high half of the output clock shows bit zero
    if (double_edge_io_out_ok) begin
      tx_data = out_edge.level ? tx0_reg : tx1_reg;  // see [R6]
    end else if (cfg_reg[CFG_OUT_REG]) begin
      tx_data = tx0_reg;
    end else begin
      tx_data = rise_edge_output_bit;
    end
    tx_data = tx_data ^ cfg_reg[CFG_OUT_INVERT];     // see [R5]
    oe_val  = cfg_reg[CFG_OE_REG] ? oe_cap_reg : core_oe;  // see [R9]
    pad_out_next = tx_en ? tx_data : 1'b0;
    pad_oe_next  = 1'b0;
    pull_up_next = 1'b0;
    pull_dn_next = 1'b0;
    clk_out_next = 1'b0;
    alt_sel_next = 1'b0;
    if (configuring) begin
      // differential pins get no pull-up while configuring
      pull_up_next = ~DIFF_PIN_SINGLE_ENDED;   // see [R11] [R12]
    end else begin
      unique case (mode)
        MODE_OUTPUT: pad_oe_next = 1'b1;       // see [R4]
        MODE_BIDIR:  pad_oe_next = oe_val;     // see [R7] [R9]
        MODE_INPUT:  alt_sel_next = cfg_reg[CFG_ALT_SEL];  // see [R2]
        MODE_CLKOUT: begin
          pad_oe_next  = 1'b1;                 // see [R10]
          clk_out_next = 1'b1;
        end
        default: begin
          // unused pin; no pull-down on differential pins
          pull_dn_next = cfg_reg[CFG_UNUSED_PULLDN]
                         & ~DIFF_PIN_SINGLE_ENDED;        // see [R13]
          pull_up_next = ~pull_dn_next;        // see [R13]
        end
      endcase
    end
  end

  // register port
  always_comb begin
    status                = '0;
    status[STAT_PAD]      = pad_sync_reg;
    status[STAT_IN0]      = in0_reg;
    status[STAT_IN1]      = in1_reg;
    status[STAT_OE]       = pad_oe_reg;
    status[STAT_PULLUP]   = pull_up_reg;
    status[STAT_PULLDN]   = pull_dn_reg;
    status[STAT_CONFIGNG] = configuring;
    cfg_next = cfg_reg;
    if (wr_en && addr == CFG_ADDR) begin
      cfg_next = wr_data & CFG_WMASK;
    end
    // data valid only in the cycle after the strobe
    rd_data_next = '0;
    if (rd_en) begin
      if (addr == CFG_ADDR) begin
        rd_data_next = cfg_reg;
      end else if (addr == STAT_ADDR) begin
        rd_data_next = status;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg       <= CFG_RESET;
      rd_data_reg   <= '0;
      pad_meta_reg  <= BIT_RESET;
      pad_sync_reg  <= BIT_RESET;
      in0_reg       <= BIT_RESET;
      in1_reg       <= BIT_RESET;
      fall_hold_reg <= BIT_RESET;
      tx0_reg       <= BIT_RESET;
      tx1_reg       <= BIT_RESET;
      oe_cap_reg    <= BIT_RESET;
      pad_out_reg   <= BIT_RESET;
      pad_oe_reg    <= BIT_RESET;
      pull_up_reg   <= BIT_RESET;
      pull_dn_reg   <= BIT_RESET;
      clk_out_reg   <= BIT_RESET;
      alt_sel_reg   <= BIT_RESET;
    end else begin
      cfg_reg       <= cfg_next;
      rd_data_reg   <= rd_data_next;
      pad_meta_reg  <= pad_meta_next;
      pad_sync_reg  <= pad_sync_next;
      in0_reg       <= in0_next;
      in1_reg       <= in1_next;
      fall_hold_reg <= fall_hold_next;
      tx0_reg       <= tx0_next;
      tx1_reg       <= tx1_next;
      oe_cap_reg    <= oe_cap_next;
      pad_out_reg   <= pad_out_next;
      pad_oe_reg    <= pad_oe_next;
      pull_up_reg   <= pull_up_next;
      pull_dn_reg   <= pull_dn_next;
      clk_out_reg   <= clk_out_next;
      alt_sel_reg   <= alt_sel_next;
    end
  end

  // clock and alternate routes stay unregistered so edges pass intact
  assign pad_out = clk_out_reg ? tree_clk : pad_out_reg;  // see [R10]
  assign alt_out = alt_sel_reg & pad_in;                  // see [R2]
  assign rd_data             = rd_data_reg;
  assign rise_edge_input_bit = in0_reg;
  assign fall_edge_input_bit = in1_reg;
  assign pad_oe              = pad_oe_reg;                // see [R17]
  assign pull_up_en          = pull_up_reg;
  assign pull_down_en        = pull_dn_reg;

endmodule // gpio_io_logic_cell

// file: bench/gpio_io_logic_cell_chk.sv
`timescale 1ns/100ps
module gpio_io_logic_cell_chk #(
  parameter bit DIFF_PIN_SINGLE_ENDED = 1'b0
) (
  input wire logic                             clk,
  input wire logic                             rst_n,
  input wire logic                             config_done,
  input wire logic                             rise_edge_input_bit,
  input wire logic                             fall_edge_input_bit,
  input wire logic                             alt_out,
  input wire logic                             pad_in,
  input wire logic                             pad_oe,
  input wire logic                             pull_up_en,
  input wire logic                             pull_down_en
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // two cycles of configuring let the registered outputs settle
  property p_cfg_oe;
    !config_done ##1 !config_done |-> !pad_oe;
  endproperty
  a_cfg_oe: assert property (p_cfg_oe)
    else $error("pad driven while configuring");
  property p_cfg_pull;
    !config_done ##1 !config_done |->
      pull_up_en == !DIFF_PIN_SINGLE_ENDED && !pull_down_en;
  endproperty
  a_cfg_pull: assert property (p_cfg_pull)
    else $error("wrong pulls while configuring");
  property p_cfg_rx;
    !config_done [*2] |-> !rise_edge_input_bit && !fall_edge_input_bit;
  endproperty
  a_cfg_rx: assert property (p_cfg_rx)
    else $error("receive active while configuring");
  property p_pulls;
    !(pull_up_en && pull_down_en);
  endproperty
  a_pulls: assert property (p_pulls)
    else $error("both pulls on");
  property p_pd_user;
    pull_down_en |-> $past(config_done);
  endproperty
  a_pd_user: assert property (p_pd_user)
    else $error("pull-down outside user mode");
  // alternate route only in user-mode input, never while driving
  property p_alt;
    alt_out |-> pad_in && !pad_oe && $past(config_done)
      && !pull_up_en && !pull_down_en;
  endproperty
  a_alt: assert property (p_alt)
    else $error("alternate route differs from pad");
  property p_diff_pd;
    DIFF_PIN_SINGLE_ENDED |-> !pull_down_en;
  endproperty
  a_diff_pd: assert property (p_diff_pd)
    else $error("pull-down on differential pin");
  property p_diff_in1;
    DIFF_PIN_SINGLE_ENDED |-> !fall_edge_input_bit;
  endproperty
  a_diff_in1: assert property (p_diff_in1)
    else $error("double-edge bit on differential pin");
endmodule // gpio_io_logic_cell_chk

bind gpio_io_logic_cell gpio_io_logic_cell_chk #(
  .DIFF_PIN_SINGLE_ENDED(DIFF_PIN_SINGLE_ENDED)
) chk (.clk, .rst_n, .config_done, .rise_edge_input_bit,
  .fall_edge_input_bit, .alt_out, .pad_in, .pad_oe, .pull_up_en,
  .pull_down_en);

// file: bench/pad_model.sv
`timescale 1ns/100ps
module pad_model (
  input  wire logic clk,
  input  wire logic pad_out,
  input  wire logic pad_oe,
  input  wire logic pull_up_en,
  input  wire logic pull_down_en,
  input  wire logic ext_en,
  input  wire logic ext_val,
  output logic      pad_in
);
  logic float_reg = 1'b0;

  // a floating pad wanders, so a stale level never passes for a pull
  always @(posedge clk) begin
    float_reg <= ~float_reg;
  end

  // wire level: cell drive, else outside driver, else pulls
  always_comb begin
    if (pad_oe) begin
      pad_in = pad_out;
    end else if (ext_en) begin
      pad_in = ext_val;
    end else if (pull_up_en) begin
      pad_in = 1'b1;
    end else if (pull_down_en) begin
      pad_in = 1'b0;
    end else begin
      pad_in = float_reg;
    end
  end
endmodule // pad_model

// file: bench/tb_gpio_io_logic_cell.sv
`timescale 1ns/100ps
module tb_gpio_io_logic_cell;
  import gpio_cell_pkg::*;
  typedef struct packed {
    logic [15:0] cfg;
    logic [1:0]  ext;
    logic        o0;
    logic        oe;
    logic [6:0]  pv;
  } row_t;
  logic        clk = 1'b0;
  logic        rst_n, wr_en, rd_en, config_done, in_clk, out_clk, tree_clk;
  logic [7:0]  addr;
  logic [31:0] wr_data, rd_data, d;
  logic        rise_edge_output_bit, fall_edge_output_bit, core_oe;
  logic        rise_edge_input_bit, fall_edge_input_bit, alt_out;
  logic        pad_in, pad_out, pad_oe, pull_up_en, pull_down_en;
  logic        ext_en, ext_val, pu2, pd2;
  int          err_total = 0;
  int          cmp_count = 0;
  int          cyc_count = 0;
  wire  [6:0]  pv = {pad_oe, pad_oe & pad_out, rise_edge_input_bit,
                     fall_edge_input_bit, alt_out, pull_up_en, pull_down_en};
  // unregistered paths only, so no pin clock edges are needed
  row_t rows [11] = '{
    '{16'h0000, 2'h3, 1'b0, 1'b0, 7'h02}, '{16'h4000, 2'h3, 1'b0, 1'b0, 7'h01},
    '{16'h0004, 2'h0, 1'b0, 1'b0, 7'h02}, '{16'h0001, 2'h3, 1'b0, 1'b0, 7'h10},
    '{16'h2001, 2'h3, 1'b0, 1'b0, 7'h14}, '{16'h0002, 2'h0, 1'b1, 1'b0, 7'h60},
    '{16'h0202, 2'h0, 1'b1, 1'b0, 7'h40}, '{16'h0003, 2'h0, 1'b1, 1'b1, 7'h70},
    '{16'h0203, 2'h0, 1'b1, 1'b1, 7'h40}, '{16'h0003, 2'h3, 1'b1, 1'b0, 7'h10},
    '{16'h0003, 2'h2, 1'b1, 1'b0, 7'h00}};

  always #12.5 clk = ~clk;

  gpio_io_logic_cell #(.DIFF_PIN_SINGLE_ENDED(1'b0)) uut (.clk, .rst_n,
    .addr, .wr_data, .wr_en, .rd_en, .rd_data, .config_done, .in_clk,
    .out_clk, .tree_clk, .rise_edge_output_bit, .fall_edge_output_bit,
    .core_oe, .rise_edge_input_bit, .fall_edge_input_bit, .alt_out,
    .pad_in, .pad_out, .pad_oe, .pull_up_en, .pull_down_en);
  // differential variant shares every input, only its pulls are compared
  gpio_io_logic_cell #(.DIFF_PIN_SINGLE_ENDED(1'b1)) uut2 (.clk, .rst_n,
    .addr, .wr_data, .wr_en, .rd_en, .rd_data(), .config_done, .in_clk,
    .out_clk, .tree_clk, .rise_edge_output_bit, .fall_edge_output_bit,
    .core_oe, .rise_edge_input_bit(), .fall_edge_input_bit(), .alt_out(),
    .pad_in, .pad_out(), .pad_oe(), .pull_up_en(pu2), .pull_down_en(pd2));
  pad_model pm (.clk, .pad_out, .pad_oe, .pull_up_en, .pull_down_en,
    .ext_en, .ext_val, .pad_in);

  task automatic summarize();
    if (err_total == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wr_data <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  // read data is looked at in the single cycle it stands
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    v = rd_data;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // hang guard, the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc_count <= cyc_count + 1;
    if (cyc_count == 3000) begin
      err_total++;
      summarize();
    end
  end

  initial begin
    {addr, wr_data, wr_en, rd_en, config_done, in_clk, out_clk} <= '0;
    {tree_clk, rise_edge_output_bit, fall_edge_output_bit} <= '0;
    {core_oe, ext_en, ext_val, rst_n} <= '0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    wt(3);
    rd(CFG_ADDR, d);
    chk(d, CFG_RESET);
    rd(STAT_ADDR, d);
    chk(d, 32'h0000_0051);
    chk(32'(pv), 32'h0000_0002);
    chk(32'(pu2), 32'h0000_0000);
    @(posedge clk);
    config_done <= 1'b1;
    foreach (rows[i]) begin
      wr(CFG_ADDR, {16'h0000, rows[i].cfg});
      {ext_en, ext_val} <= rows[i].ext;
      rise_edge_output_bit <= rows[i].o0;
      core_oe <= rows[i].oe;
      wt(8);
      chk(32'(pv), 32'(rows[i].pv));
    end
    wr(CFG_ADDR, 32'hFFFF_FFFF);
    rd(CFG_ADDR, d);
    chk(d, CFG_WMASK);
    rd(8'h08, d);
    chk(d, 32'h0000_0000);
    // registered input: pad moves without an edge, output must not
    wr(CFG_ADDR, 32'h0000_0009);
    {ext_en, ext_val} <= 2'h3;
    wt(8);
    chk(32'(rise_edge_input_bit), 32'h0000_0000);
    @(posedge clk) in_clk <= 1'b1;
    wt(8);
    chk(32'(rise_edge_input_bit), 32'h0000_0001);
    @(posedge clk) ext_val <= 1'b0;
    wt(8);
    chk(32'(rise_edge_input_bit), 32'h0000_0001);
    // double-edge receive, pad settles well before each clock edge
    wr(CFG_ADDR, 32'h0000_0409);
    @(posedge clk) in_clk <= 1'b0;
    wt(8);
    @(posedge clk) ext_val <= 1'b1;
    wt(4);
    @(posedge clk) in_clk <= 1'b1;
    wt(8);
    @(posedge clk) ext_val <= 1'b0;
    wt(4);
    @(posedge clk) in_clk <= 1'b0;
    wt(8);
    chk(32'({rise_edge_input_bit, fall_edge_input_bit}),
        32'h2);
    // resync: falling sample waits for the next rising edge
    wr(CFG_ADDR, 32'h0000_1409);
    @(posedge clk) ext_val <= 1'b1;
    wt(4);
    @(posedge clk) in_clk <= 1'b1;
    wt(8);
    @(posedge clk) in_clk <= 1'b0;
    wt(8);
    chk(32'(fall_edge_input_bit), 32'h0000_0000);
    @(posedge clk) ext_val <= 1'b0;
    wt(4);
    @(posedge clk) in_clk <= 1'b1;
    wt(8);
    chk(32'({rise_edge_input_bit, fall_edge_input_bit}), 32'h1);
    // double-edge transmit
    wr(CFG_ADDR, 32'h0000_0822);
    {ext_en, rise_edge_output_bit, fall_edge_output_bit} <= 3'h2;
    wt(4);
    @(posedge clk) out_clk <= 1'b1;
    wt(8);
    chk(32'(pad_out), 32'h0000_0001);
    @(posedge clk) out_clk <= 1'b0;
    wt(8);
    chk(32'(pad_out), 32'h0000_0000);
    @(posedge clk) fall_edge_output_bit <= 1'b1;
    wt(8);
    chk(32'(pad_out), 32'h0000_0000);
    // clock-out passes the tree clock straight through
    wr(CFG_ADDR, 32'h0000_0006);
    @(posedge clk) tree_clk <= 1'b1;
    wt(1);
    chk(32'(pad_out), 32'h0000_0001);
    @(posedge clk) tree_clk <= 1'b0;
    wt(1);
    chk(32'(pad_out), 32'h0000_0000);
    // bidir: input on falling in edge, data falling, enable rising out edge
    wr(CFG_ADDR, 32'h0000_00FB);
    {rise_edge_output_bit, core_oe} <= 2'h1;
    wt(8);
    chk(32'({pad_oe, rise_edge_input_bit}), 32'h0);
    @(posedge clk) out_clk <= 1'b1;
    wt(8);
    chk(32'({pad_oe, pad_out}), 32'h3);
    @(posedge clk) in_clk <= 1'b0;
    wt(8);
    chk(32'(rise_edge_input_bit), 32'h1);
    @(posedge clk) out_clk <= 1'b0;
    wt(8);
    chk(32'({pad_oe, pad_out, rise_edge_input_bit}), 32'h5);
    wr(CFG_ADDR, 32'h0000_4000);
    wt(4);
    chk(32'({pu2, pd2}), 32'h2);
    // mid-run reset drops every drive and pull, then back to idle
    @(posedge clk) rst_n <= 1'b0;
    wt(2);
    chk(32'({pv, pad_out, pu2, pd2}), 32'h0);
    @(posedge clk) rst_n <= 1'b1;
    wt(3);
    rd(CFG_ADDR, d);
    chk(d, CFG_RESET);
    chk(32'(pv), 32'h0000_0002);
    summarize();
  end
endmodule // tb_gpio_io_logic_cell
